// ===== verilog/rst_irq_params.svh
`ifndef RST_IRQ_PARAMS_SVH
`define RST_IRQ_PARAMS_SVH

// ****************************************************************
// fixed values applied by every reset
// ****************************************************************
`define SP_RESET_VAL 8'hFF
`define TIMER_PRESET_VAL 16'hFFFC

// ****************************************************************
// vector addresses (high byte first, low byte at +1)
// ****************************************************************
`define VEC_RESET 13'h1FFE
`define VEC_SWI 13'h1FFC
`define VEC_EXT 13'h1FFA
`define VEC_TIMER 13'h1FF8

// ****************************************************************
// service register and flag bit positions
// ****************************************************************
`define WDG_SERVICE_ADDR 13'h1FF0
`define WDG_CLEAR_BIT 0
`define CCR_MASK_BIT 3

// ****************************************************************
// timing counts
// ****************************************************************
`define CLK_PERIOD_NS 10
`define TCYC_NS 500
`define POR_DELAY_TCYC 4064
`define POR_DELAY_CYC (`POR_DELAY_TCYC * `TCYC_NS / `CLK_PERIOD_NS)
`define RST_PIN_MIN_NS (`TCYC_NS * 3 / 2)
`define RST_PIN_MIN_CYC ((`RST_PIN_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDG_TIMEOUT_US 65500
`define WDG_TIMEOUT_CYC (`WDG_TIMEOUT_US * 1000 / `CLK_PERIOD_NS)
`define WDG_STAGES 18

`endif

// ===== verilog/rst_irq_pkg.sv
package rst_irq_pkg;
  // ****************************************************************
  // shared types
  // ****************************************************************
  typedef logic [12:0] addr_t;
  typedef logic [7:0] byte_t;
  // sequencer states
  typedef enum logic [2:0] {ST_RESET, ST_FETCH, ST_RUN, ST_PUSH, ST_PULL} seq_state_e;
endpackage

// ===== verilog/wdg_if.sv
`timescale 1ns/1ns
// ****************************************************************
// link between sequencer and watchdog counter
// ****************************************************************
interface wdg_if;
  logic ce;
  logic clear;
  logic expire;
  modport ctrl (output ce, output clear, input expire);
  modport counter (input ce, input clear, output expire);
endinterface

// ===== verilog/watchdog_counter.sv
`timescale 1ns/1ns
`include "rst_irq_params.svh"
module watchdog_counter #(
  parameter int TIMEOUT_CYC = `WDG_TIMEOUT_CYC,
  parameter int STAGES = `WDG_STAGES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  wdg_if.counter port
);
  // prescaler rounds down: timeout exceeds nominal only when the tick is clamped to one
  localparam int TICK_RAW = TIMEOUT_CYC / (2 ** STAGES);
  localparam int TICK = (TICK_RAW < 1) ? 1 : TICK_RAW;
  localparam int TW = (TICK < 2) ? 1 : $clog2(TICK);

  logic [TW-1:0] pre_q, pre_d;
  logic [STAGES-1:0] stage_q, stage_d;
  logic expire_q, expire_d;
  logic tick;

  // ****************************************************************
  // prescaler plus counter chain; a service write restarts both
  // ****************************************************************
  always_comb begin
    pre_d = pre_q;
    stage_d = stage_q;
    expire_d = 1'b0;
    tick = (pre_q == TW'(TICK - 1));
    if (port.clear) begin
      pre_d = '0;
      stage_d = '0;
    end else begin
      pre_d = tick ? '0 : TW'(pre_q + 1'b1);
      if (tick) begin
        stage_d = STAGES'(stage_q + 1'b1);
        expire_d = &stage_q;
      end
    end
  end

  // registered state, frozen while the clock enable is low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_q <= '0;
      stage_q <= '0;
      expire_q <= 1'b0;
    end else if (port.ce) begin
      pre_q <= pre_d;
      stage_q <= stage_d;
      expire_q <= expire_d;
    end
  end

  assign port.expire = expire_q;
endmodule

// ===== verilog/reset_interrupt_sequencer.sv
`timescale 1ns/1ns
`include "rst_irq_params.svh"
// Functional notes
// - any reset aborts the running instruction immediately
// - reset clears all port direction bits
// - reset loads stack pointer with FF
// - reset sets the global interrupt mask
// - reset clears timer prescaler, presets counter, enables
// - reset clears stop and wait latches
// - reset vector fetched high then low byte
// - power-up hold, then wait for pin high
// - reset pin low one and half cycles
// - reset pin is never driven by device
// - watchdog expiry raises an ordinary internal reset
// - writing zero to clear bit restarts watchdog
// - service register reads return underlying rom
// - interrupts taken only at instruction boundaries
// - timer request needs flag, enable, mask clear
// - entry pushes pcl pch x a ccr
// - return pulls ccr a x pch pcl
// - external interrupt wins over timer interrupt
// - software trap ignores mask, own vector
// - external interrupt when pin low, mask clear
// - all timer sources share one vector
// - external latch clears at vector fetch
// - level option: pending while pin held low
module reset_interrupt_sequencer #(
  parameter int POR_CYC = `POR_DELAY_CYC,
  parameter int WDG_TIMEOUT_CYC = `WDG_TIMEOUT_CYC,
  parameter int WDG_STAGES = `WDG_STAGES,
  parameter bit WDG_ENABLE = 1'b1,
  parameter bit IRQ_LEVEL = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic reset_pin_n_i,
  input wire logic irq_pin_n_i,
  input wire rst_irq_pkg::addr_t cpu_addr_i,
  input wire logic cpu_re_i,
  input wire logic cpu_we_i,
  input wire rst_irq_pkg::byte_t cpu_wdata_i,
  output rst_irq_pkg::byte_t cpu_rdata_o,
  input wire logic cpu_inst_done_i,
  input wire logic cpu_swi_i,
  input wire logic cpu_rti_i,
  input wire rst_irq_pkg::addr_t cpu_pc_i,
  input wire rst_irq_pkg::byte_t cpu_x_i,
  input wire rst_irq_pkg::byte_t cpu_a_i,
  input wire rst_irq_pkg::byte_t cpu_ccr_i,
  input wire rst_irq_pkg::byte_t cpu_sp_i,
  input wire logic [2:0] timer_flags_i,
  input wire logic [2:0] timer_enables_i,
  output rst_irq_pkg::addr_t mem_addr_o,
  output logic mem_re_o,
  output logic mem_we_o,
  output rst_irq_pkg::byte_t mem_wdata_o,
  input wire rst_irq_pkg::byte_t mem_rdata_i,
  output logic cpu_reset_o,
  output logic cpu_hold_o,
  output logic ddr_clear_o,
  output logic timer_reset_o,
  output logic [15:0] timer_preset_o,
  output logic lowpower_clear_o,
  output logic pc_load_o,
  output rst_irq_pkg::addr_t pc_value_o,
  output logic sp_load_o,
  output rst_irq_pkg::byte_t sp_value_o,
  output logic mask_set_o,
  output logic regs_load_o,
  output rst_irq_pkg::byte_t ccr_value_o,
  output rst_irq_pkg::byte_t a_value_o,
  output rst_irq_pkg::byte_t x_value_o
);
  import rst_irq_pkg::*;

  localparam int RST_CYC = `RST_PIN_MIN_CYC;
  localparam int RST_W = $clog2(RST_CYC + 1);
  localparam int POR_W = $clog2(POR_CYC + 1);

  // ****************************************************************
  // pin synchronisers (bit 0 reset pin, bit 1 interrupt pin)
  // ****************************************************************
  logic [1:0] pin_raw;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  // reset pin is sampled only, never driven
  assign pin_raw = {irq_pin_n_i, reset_pin_n_i};

  // two stages per pin; stage one feeds stage two only
  for (genvar g = 0; g < 2; g++) begin : g_sync
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        sync1_q[g] <= 1'b1;
        sync2_q[g] <= 1'b1;
      end else if (ce_i) begin
        sync1_q[g] <= pin_raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  logic rst_pin_high;
  logic irq_pin_high;
  assign rst_pin_high = sync2_q[0];
  assign irq_pin_high = sync2_q[1];

  // ****************************************************************
  // reset sources: power-up delay and filtered pin
  // ****************************************************************
  logic [POR_W-1:0] por_cnt_q, por_cnt_d;
  logic por_done_q, por_done_d;
  logic [RST_W-1:0] pin_cnt_q, pin_cnt_d;
  logic pin_active_q, pin_active_d;

  // lows shorter than the minimum are glitches
  always_comb begin
    por_cnt_d = por_cnt_q;
    por_done_d = por_done_q;
    if (!por_done_q) begin
      por_cnt_d = POR_W'(por_cnt_q + 1'b1);
      por_done_d = (por_cnt_q == POR_W'(POR_CYC - 1));
    end
    pin_cnt_d = '0;
    pin_active_d = 1'b0;
    if (!rst_pin_high) begin
      pin_cnt_d = (pin_cnt_q == RST_W'(RST_CYC)) ? pin_cnt_q : RST_W'(pin_cnt_q + 1'b1);
      pin_active_d = pin_active_q || (pin_cnt_q == RST_W'(RST_CYC - 1));
    end
  end

  // delay counter restarts only on power-up reset; pin counter also clears while the pin is high
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
      pin_cnt_q <= '0;
      pin_active_q <= 1'b0;
    end else if (ce_i) begin
      por_cnt_q <= por_cnt_d;
      por_done_q <= por_done_d;
      pin_cnt_q <= pin_cnt_d;
      pin_active_q <= pin_active_d;
    end
  end

  // ****************************************************************
  // watchdog, built only with the option
  // ****************************************************************
  seq_state_e state_q, state_d;
  logic reset_seq;
  logic svc_write;
  wdg_if wdg ();

  // a service write counts only while the core runs
  assign svc_write = WDG_ENABLE && (state_q == ST_RUN) && cpu_we_i && (cpu_addr_i == `WDG_SERVICE_ADDR)
                     && !cpu_wdata_i[`WDG_CLEAR_BIT];
  assign wdg.ce = ce_i;
  assign wdg.clear = svc_write || reset_seq;

  if (WDG_ENABLE) begin : g_wdg
    watchdog_counter #(
      .TIMEOUT_CYC(WDG_TIMEOUT_CYC),
      .STAGES(WDG_STAGES)
    ) u_wdg (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .port(wdg.counter)
    );
  end else begin : g_no_wdg
    assign wdg.expire = 1'b0;
  end

  // ****************************************************************
  // interrupt qualification
  // ****************************************************************
  logic irq_prev_q, irq_prev_d;
  logic irq_latch_q, irq_latch_d;
  logic irq_clr;
  logic mask;
  logic ext_req;
  logic timer_req;

  assign mask = cpu_ccr_i[`CCR_MASK_BIT];
  assign ext_req = (irq_latch_q || (IRQ_LEVEL && !irq_pin_high)) && !mask;
  assign timer_req = (|(timer_flags_i & timer_enables_i)) && !mask;

  // a new edge beats the fetch clear
  always_comb begin
    irq_prev_d = irq_pin_high;
    irq_latch_d = irq_latch_q;
    if (irq_clr || reset_seq) begin
      irq_latch_d = 1'b0;
    end
    if (irq_prev_q && !irq_pin_high) begin
      irq_latch_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_prev_q <= 1'b1;
      irq_latch_q <= 1'b0;
    end else if (ce_i) begin
      irq_prev_q <= irq_prev_d;
      irq_latch_q <= irq_latch_d;
    end
  end

  // ****************************************************************
  // sequencer: reset hold, vector fetch, stacking, unstacking
  // ****************************************************************
  logic [2:0] step_q, step_d;
  addr_t vec_q, vec_d;
  byte_t sp_q, sp_d;
  byte_t hi_q, hi_d;
  byte_t snap_q [5];
  byte_t snap_d [5];
  logic pc_load_q, pc_load_d;
  addr_t pc_value_q, pc_value_d;
  logic sp_load_q, sp_load_d;
  byte_t sp_value_q, sp_value_d;
  logic mask_set_q, mask_set_d;
  logic regs_load_q, regs_load_d;
  byte_t ccr_value_q, ccr_value_d;
  byte_t a_value_q, a_value_d;
  byte_t x_value_q, x_value_d;
  logic seq_re;
  logic seq_we;
  addr_t seq_addr;
  byte_t seq_wdata;

  // core held in reset until the reset vector loads
  assign reset_seq = (state_q == ST_RESET) || ((state_q == ST_FETCH) && (vec_q == `VEC_RESET));

  always_comb begin
    state_d = state_q;
    step_d = step_q;
    vec_d = vec_q;
    sp_d = sp_q;
    hi_d = hi_q;
    for (int i = 0; i < 5; i++) begin
      snap_d[i] = snap_q[i];
    end
    pc_load_d = 1'b0;
    pc_value_d = pc_value_q;
    sp_load_d = 1'b0;
    sp_value_d = sp_value_q;
    mask_set_d = 1'b0;
    regs_load_d = 1'b0;
    ccr_value_d = ccr_value_q;
    a_value_d = a_value_q;
    x_value_d = x_value_q;
    seq_re = 1'b0;
    seq_we = 1'b0;
    seq_addr = vec_q;
    seq_wdata = snap_q[0];
    irq_clr = 1'b0;
    case (state_q)
      ST_RESET: begin
        step_d = '0;
        vec_d = `VEC_RESET;
        // leave only once the delay is over and the pin reads high
        if (por_done_q && rst_pin_high && !pin_active_q) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // memory answers one cycle after the read strobe
        if (step_q == 3'd0) begin
          seq_re = 1'b1;
          seq_addr = vec_q;
          irq_clr = (vec_q == `VEC_EXT);
          step_d = 3'd1;
        end else if (step_q == 3'd1) begin
          seq_re = 1'b1;
          seq_addr = addr_t'(vec_q + 1'b1);
          hi_d = mem_rdata_i;
          step_d = 3'd2;
        end else begin
          pc_value_d = {hi_q[4:0], mem_rdata_i};
          pc_load_d = 1'b1;
          state_d = ST_RUN;
          step_d = '0;
        end
      end
      ST_RUN: begin
        snap_d[0] = cpu_pc_i[7:0];
        snap_d[1] = {3'b000, cpu_pc_i[12:8]};
        snap_d[2] = cpu_x_i;
        snap_d[3] = cpu_a_i;
        snap_d[4] = cpu_ccr_i;
        sp_d = cpu_sp_i;
        step_d = '0;
        if (cpu_rti_i) begin
          state_d = ST_PULL;
        end else if (cpu_swi_i) begin
          vec_d = `VEC_SWI;
          state_d = ST_PUSH;
        end else if (cpu_inst_done_i && ext_req) begin
          vec_d = `VEC_EXT;
          state_d = ST_PUSH;
        end else if (cpu_inst_done_i && timer_req) begin
          vec_d = `VEC_TIMER;
          state_d = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // one byte per cycle, stack pointer walks downward
        seq_we = 1'b1;
        seq_addr = {5'h00, byte_t'(sp_q - {5'h00, step_q})};
        seq_wdata = snap_q[step_q];
        step_d = 3'(step_q + 1'b1);
        if (step_q == 3'd4) begin
          sp_value_d = byte_t'(sp_q - 8'h05);
          sp_load_d = 1'b1;
          mask_set_d = 1'b1;
          state_d = ST_FETCH;
          step_d = '0;
        end
      end
      ST_PULL: begin
        // reads run one step ahead of the captures
        if (step_q != 3'd5) begin
          seq_re = 1'b1;
          seq_addr = {5'h00, byte_t'(sp_q + 8'h01 + {5'h00, step_q})};
        end
        if (step_q != 3'd0) begin
          snap_d[step_q - 3'd1] = mem_rdata_i;
        end
        step_d = 3'(step_q + 1'b1);
        if (step_q == 3'd5) begin
          ccr_value_d = snap_q[0];
          a_value_d = snap_q[1];
          x_value_d = snap_q[2];
          pc_value_d = {snap_q[3][4:0], mem_rdata_i};
          pc_load_d = 1'b1;
          regs_load_d = 1'b1;
          sp_value_d = byte_t'(sp_q + 8'h05);
          sp_load_d = 1'b1;
          state_d = ST_RUN;
          step_d = '0;
        end
      end
      default: begin
        state_d = ST_RESET;
        step_d = '0;
      end
    endcase
    // any reset cuts every sequence short
    if (pin_active_q || wdg.expire) begin
      sp_value_d = `SP_RESET_VAL;
      state_d = ST_RESET;
      step_d = '0;
      pc_load_d = 1'b0;
      sp_load_d = 1'b0;
      mask_set_d = 1'b0;
      regs_load_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_RESET;
      step_q <= '0;
      vec_q <= `VEC_RESET;
      sp_q <= `SP_RESET_VAL;
      hi_q <= '0;
      for (int i = 0; i < 5; i++) begin
        snap_q[i] <= '0;
      end
      pc_load_q <= 1'b0;
      pc_value_q <= '0;
      sp_load_q <= 1'b0;
      sp_value_q <= `SP_RESET_VAL;
      mask_set_q <= 1'b0;
      regs_load_q <= 1'b0;
      ccr_value_q <= '0;
      a_value_q <= '0;
      x_value_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      step_q <= step_d;
      vec_q <= vec_d;
      sp_q <= sp_d;
      hi_q <= hi_d;
      for (int i = 0; i < 5; i++) begin
        snap_q[i] <= snap_d[i];
      end
      pc_load_q <= pc_load_d;
      pc_value_q <= pc_value_d;
      sp_load_q <= sp_load_d;
      sp_value_q <= sp_value_d;
      mask_set_q <= mask_set_d;
      regs_load_q <= regs_load_d;
      ccr_value_q <= ccr_value_d;
      a_value_q <= a_value_d;
      x_value_q <= x_value_d;
    end
  end

  // ****************************************************************
  // memory port mux and outputs
  // ****************************************************************
  // core owns memory while running; service reads see rom
  assign mem_addr_o = (state_q == ST_RUN) ? cpu_addr_i : seq_addr;
  assign mem_re_o = (state_q == ST_RUN) ? cpu_re_i : seq_re;
  assign mem_we_o = (state_q == ST_RUN) ? cpu_we_i : seq_we;
  assign mem_wdata_o = (state_q == ST_RUN) ? cpu_wdata_i : seq_wdata;
  assign cpu_rdata_o = mem_rdata_i;

  // reset side effects stand for the whole reset sequence
  assign cpu_reset_o = reset_seq;
  assign cpu_hold_o = (state_q == ST_PUSH) || (state_q == ST_PULL) || ((state_q == ST_FETCH) && !reset_seq);
  assign ddr_clear_o = reset_seq;
  assign timer_reset_o = reset_seq;
  assign timer_preset_o = `TIMER_PRESET_VAL;
  assign lowpower_clear_o = reset_seq;
  assign pc_load_o = pc_load_q;
  assign pc_value_o = pc_value_q;
  assign sp_load_o = sp_load_q || reset_seq;
  assign sp_value_o = sp_value_q;
  assign mask_set_o = mask_set_q || reset_seq;
  assign regs_load_o = regs_load_q;
  assign ccr_value_o = ccr_value_q;
  assign a_value_o = a_value_q;
  assign x_value_o = x_value_q;
endmodule

// ===== bench/rst_seq_checker_chk.sv
`timescale 1ns/1ns
module rst_seq_checker #(
  parameter int WDG_TIMEOUT_CYC = 256,
  parameter int WDG_STAGES = 4,
  parameter bit WDG_ENABLE = 1'b1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reset_pin_n_i,
  input wire rst_irq_pkg::addr_t cpu_addr_i,
  input wire logic cpu_we_i,
  input wire rst_irq_pkg::byte_t cpu_wdata_i,
  input wire rst_irq_pkg::addr_t mem_addr_o,
  input wire logic mem_re_o,
  input wire logic mem_we_o,
  input wire rst_irq_pkg::byte_t mem_rdata_i,
  input wire logic cpu_reset_o,
  input wire logic cpu_hold_o,
  input wire logic ddr_clear_o,
  input wire logic timer_reset_o,
  input wire logic [15:0] timer_preset_o,
  input wire logic lowpower_clear_o,
  input wire logic pc_load_o,
  input wire rst_irq_pkg::addr_t pc_value_o,
  input wire logic sp_load_o,
  input wire rst_irq_pkg::byte_t sp_value_o,
  input wire logic mask_set_o,
  input wire logic regs_load_o
);
  import rst_irq_pkg::*;
  // slack for prescaler phase
  localparam int LIM = ((WDG_TIMEOUT_CYC >> WDG_STAGES) << WDG_STAGES) + 24;
  logic [7:0] pin_q, pin_d;
  int wdg_q, wdg_d;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // pin-low run, cycles since service
  always_comb begin
    pin_d = reset_pin_n_i ? 8'h00 : pin_q + {7'h00, pin_q != 8'hc8};
    wdg_d = (cpu_reset_o || (cpu_we_i && cpu_addr_i == 13'h1ff0 && !cpu_wdata_i[0])) ? 0 : wdg_q + 1;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_q <= 8'h00;
      wdg_q <= 0;
    end else begin
      pin_q <= pin_d;
      wdg_q <= wdg_d;
    end
  end
  AST_RESET_LEVELS: assert property (cpu_reset_o |-> ddr_clear_o && timer_reset_o && lowpower_clear_o
    && timer_preset_o == 16'hfffc) else $error("reset side effects missing");
  AST_RESET_SP: assert property (cpu_reset_o |-> sp_load_o && sp_value_o == 8'hff && mask_set_o)
    else $error("reset stack or mask wrong");
  AST_RESET_VEC: assert property ($fell(cpu_reset_o) |-> pc_load_o && $past(mem_addr_o, 3) == 13'h1ffe
    && $past(mem_addr_o, 2) == 13'h1fff && {3'b000, pc_value_o[12:8]} == $past(mem_rdata_i, 2)
    && pc_value_o[7:0] == $past(mem_rdata_i)) else $error("reset vector fetch wrong");
  AST_PIN_RESET: assert property (pin_q == 8'h50 |-> cpu_reset_o) else $error("pin reset missed");
  AST_WDG_FIRE: assert property (WDG_ENABLE && wdg_q == LIM |-> cpu_reset_o)
    else $error("watchdog did not expire");
  AST_PUSH: assert property ($rose(mem_we_o) && cpu_hold_o |-> mem_we_o [*5] ##1
    (mask_set_o && sp_load_o && mem_re_o) ##1 mem_re_o ##1 !mem_re_o ##1 pc_load_o) else $error("entry sequence wrong");
  AST_PUSH_DOWN: assert property (cpu_hold_o && mem_we_o && $past(mem_we_o) |->
    mem_addr_o == $past(mem_addr_o) - 13'h0001) else $error("push address not descending");
  AST_VEC_ADDR: assert property (cpu_hold_o && mem_re_o && $past(mem_we_o) |->
    mem_addr_o inside {13'h1ff8, 13'h1ffa, 13'h1ffc}) else $error("bad vector address");
  AST_PULL: assert property ($rose(cpu_hold_o) && !mem_we_o && !cpu_reset_o |-> mem_re_o [*5] ##1
    !mem_re_o ##1 (regs_load_o && pc_load_o && sp_load_o)) else $error("return sequence wrong");
  cover property ($fell(cpu_reset_o));
  cover property (regs_load_o);
  cover property (cpu_hold_o && mem_we_o);
endmodule
bind reset_interrupt_sequencer rst_seq_checker #(.WDG_TIMEOUT_CYC(WDG_TIMEOUT_CYC), .WDG_STAGES(WDG_STAGES),
  .WDG_ENABLE(WDG_ENABLE)) chk (.clk_i, .reset_i, .reset_pin_n_i, .cpu_addr_i, .cpu_we_i, .cpu_wdata_i, .mem_addr_o,
  .mem_re_o, .mem_we_o, .mem_rdata_i, .cpu_reset_o, .cpu_hold_o, .ddr_clear_o, .timer_reset_o, .timer_preset_o,
  .lowpower_clear_o, .pc_load_o, .pc_value_o, .sp_load_o, .sp_value_o, .mask_set_o, .regs_load_o);

// ===== bench/irq_source_model.sv
`timescale 1ns/1ns
// ****
// reset and interrupt sources, program memory
// ****
module irq_source_model (
  input wire logic clk_i,
  input wire logic rst_req_i,
  input wire logic irq_req_i,
  input wire rst_irq_pkg::addr_t mem_addr_i,
  input wire logic mem_re_i,
  input wire logic mem_we_i,
  input wire rst_irq_pkg::byte_t mem_wdata_i,
  output logic reset_pin_n_o,
  output logic irq_pin_n_o,
  output rst_irq_pkg::byte_t mem_rdata_o
);
  import rst_irq_pkg::*;
  byte_t mem [8192];
  // pulled-up pins; sources only pull low
  assign reset_pin_n_o = !rst_req_i;
  assign irq_pin_n_o = !irq_req_i;
  // vectors, service-address rom byte, unstack frame
  initial begin
    mem_rdata_o = 8'h00;
    {mem[13'h1ff0], mem[13'h1ff8], mem[13'h1ff9], mem[13'h1ffa], mem[13'h1ffb]} = 40'h5a_0cde_0bcd;
    {mem[13'h1ffc], mem[13'h1ffd], mem[13'h1ffe], mem[13'h1fff]} = 32'h0abc_1234;
    {mem[13'h00f1], mem[13'h00f2], mem[13'h00f3], mem[13'h00f4], mem[13'h00f5]} = 40'h21_4365_0f87;
  end
  // one-cycle reads; idle data toggles
  always @(posedge clk_i) begin
    if (mem_we_i) mem[mem_addr_i] <= mem_wdata_i;
    mem_rdata_o <= mem_re_i ? mem[mem_addr_i] : ~mem_rdata_o;
  end
endmodule

// ===== bench/test_reset_interrupt_sequencer.sv
`timescale 1ns/1ns
module test_reset_interrupt_sequencer;
  import rst_irq_pkg::*;
  logic clk_i, reset_i, cpu_re_i, cpu_we_i, cpu_inst_done_i, cpu_swi_i, cpu_rti_i, rst_req, irq_req;
  logic reset_pin_n_i, irq_pin_n_i, mem_re_o, mem_we_o, cpu_reset_o, cpu_hold_o, ddr_clear_o;
  logic timer_reset_o, lowpower_clear_o, pc_load_o, sp_load_o, mask_set_o, regs_load_o;
  logic [2:0] timer_flags_i, timer_enables_i;
  logic [15:0] timer_preset_o;
  addr_t cpu_addr_i, cpu_pc_i, mem_addr_o, pc_value_o;
  byte_t cpu_wdata_i, cpu_rdata_o, cpu_x_i, cpu_a_i, cpu_ccr_i, cpu_sp_i, mem_wdata_o, mem_rdata_i;
  byte_t sp_value_o, ccr_value_o, a_value_o, x_value_o;
  byte_t stk [5];
  addr_t wa [8];
  byte_t wd [8];
  int bad_count = 0;
  int n_tests = 0;
  int w = 0;
  int n;
  // short counts keep the run brief
  reset_interrupt_sequencer #(.POR_CYC(20), .WDG_TIMEOUT_CYC(256), .WDG_STAGES(4)) uut (.ce_i(1'b1), .*);
  irq_source_model partner (.clk_i(clk_i), .rst_req_i(rst_req), .irq_req_i(irq_req), .mem_addr_i(mem_addr_o),
    .mem_re_i(mem_re_o), .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o), .reset_pin_n_o(reset_pin_n_i),
    .irq_pin_n_o(irq_pin_n_i), .mem_rdata_o(mem_rdata_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // log stacking writes
  always @(posedge clk_i) begin
    if (cpu_hold_o === 1'b1 && mem_we_o === 1'b1 && w < 8) begin
      wa[w] = mem_addr_o;
      wd[w] = mem_wdata_o;
      w++;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task wr(input addr_t a, input byte_t d);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_we_i <= 1'b1;
    @(posedge clk_i);
    cpu_we_i <= 1'b0;
  endtask
  // service, then pulse {swi, rti, done}
  task go(input logic [2:0] k);
    w = 0;
    wr(13'h1ff0, 8'h00);
    {cpu_swi_i, cpu_rti_i, cpu_inst_done_i} <= k;
    @(posedge clk_i);
    {cpu_swi_i, cpu_rti_i, cpu_inst_done_i} <= 3'b000;
  endtask
  // no load: count a hang and stop
  task wpc(input int lim);
    for (int i = 0; i < lim && pc_load_o !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    if (pc_load_o !== 1'b1) begin
      chk(pc_load_o, 16'h0001, "pc load");
      report_and_stop();
    end
  endtask
  task quiet(input logic [2:0] k);
    n = 0;
    go(k);
    repeat (12) begin
      @(posedge clk_i);
      n += (cpu_hold_o !== 1'b0);
    end
  endtask
  task ent(input logic [2:0] k);
    go(k);
    stk = '{cpu_pc_i[7:0], {3'b000, cpu_pc_i[12:8]}, cpu_x_i, cpu_a_i, cpu_ccr_i};
    wpc(20);
    chk(16'(w), 16'h0005, "push count");
    for (int i = 0; i < 5; i++) begin
      chk(wa[i], {5'h00, cpu_sp_i} - 13'(i), "push addr");
      chk(wd[i], stk[i], "push data");
    end
    chk(sp_value_o, cpu_sp_i - 8'h05, "sp after push");
  endtask
  initial begin
    {reset_i, rst_req, irq_req, cpu_re_i, cpu_we_i, cpu_inst_done_i, cpu_swi_i, cpu_rti_i} <= 8'hc0;
    {timer_flags_i, timer_enables_i, cpu_addr_i, cpu_wdata_i} <= 27'h000_0000;
    {cpu_pc_i, cpu_x_i, cpu_a_i, cpu_ccr_i, cpu_sp_i} <= 45'h1a5c_1122_08ff;
    repeat (5) @(posedge clk_i);
    chk({ddr_clear_o, timer_reset_o, lowpower_clear_o, mask_set_o}, 16'h000f, "reset levels");
    chk({sp_load_o, sp_value_o}, 16'h01ff, "reset sp");
    chk(timer_preset_o, 16'hfffc, "timer preset");
    reset_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    chk(cpu_reset_o, 16'h0001, "pin held low");
    rst_req <= 1'b0;
    wpc(400);
    chk(pc_value_o, 16'h1234, "reset vector");
    cpu_addr_i <= 13'h1ff0;
    cpu_re_i <= 1'b1;
    @(posedge clk_i);
    cpu_re_i <= 1'b0;
    @(posedge clk_i);
    chk(cpu_rdata_o, 16'h005a, "service read");
    ent(3'b100);
    chk(pc_value_o, 16'h0abc, "trap vector");
    irq_req <= 1'b1;
    repeat (4) @(posedge clk_i);
    quiet(3'b001);
    chk(16'(n), 16'h0000, "masked ext");
    cpu_ccr_i <= 8'h00;
    ent(3'b001);
    chk(pc_value_o, 16'h0bcd, "ext vector");
    irq_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    quiet(3'b001);
    chk(16'(n), 16'h0000, "ext cleared");
    for (int i = 0; i < 3; i++) begin
      {timer_flags_i, timer_enables_i} <= {3'b001 << i, 3'b001 << i};
      quiet(3'b000);
      chk(16'(n), 16'h0000, "no boundary");
      ent(3'b001);
      chk(pc_value_o, 16'h0cde, "timer vector");
    end
    {timer_flags_i, timer_enables_i} <= 6'h0a;
    quiet(3'b001);
    chk(16'(n), 16'h0000, "flag without enable");
    {cpu_ccr_i, timer_enables_i} <= 11'h041;
    quiet(3'b001);
    chk(16'(n), 16'h0000, "timer masked");
    {cpu_ccr_i, irq_req} <= 9'h001;
    repeat (4) @(posedge clk_i);
    ent(3'b001);
    chk(pc_value_o, 16'h0bcd, "ext before timer");
    {irq_req, timer_flags_i, cpu_sp_i} <= 12'h0f0;
    go(3'b010);
    wpc(20);
    chk({regs_load_o, 15'(w)}, 16'h8000, "unstack load");
    chk({ccr_value_o, a_value_o}, 16'h2143, "ccr and a");
    chk({x_value_o, sp_value_o}, 16'h65f5, "x and sp");
    chk(pc_value_o, 16'h0f87, "return pc");
    rst_req <= 1'b1;
    repeat (30) @(posedge clk_i);
    rst_req <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(cpu_reset_o, 16'h0000, "short pin pulse");
    rst_req <= 1'b1;
    repeat (100) @(posedge clk_i);
    chk(cpu_reset_o, 16'h0001, "pin reset");
    rst_req <= 1'b0;
    wpc(400);
    chk(pc_value_o, 16'h1234, "pin reset vector");
    repeat (3) begin
      wr(13'h1ff0, 8'h00);
      repeat (200) @(posedge clk_i);
      chk(cpu_reset_o, 16'h0000, "serviced watchdog");
    end
    wr(13'h1ff0, 8'h00);
    @(posedge clk_i);
    wr(13'h1ff0, 8'h01);
    for (n = 0; n < 400 && cpu_reset_o !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    chk(n >= 230 && n <= 290, 16'h0001, "watchdog expiry");
    wpc(400);
    chk(pc_value_o, 16'h1234, "watchdog reset vector");
    report_and_stop();
  end
endmodule
